/* File: bench/spsq_mech.sv */
// drive mechanics model answering motor and head commands
`timescale 1ns/10ps
module spsq_mech (
  // clock
  input wire clk,
  // commands
  input wire motor_run,
  input wire head_load,
  input wire jam,
  // status
  output logic at_speed = 0,
  output logic at_track0 = 0,
  output logic spindle_stopped = 1
);
  int cnt = 0;
  logic last = 0;
  // speed is gained only after a run of steady drive and lost as soon as drive drops
  always @(posedge clk) begin
    last <= motor_run;
    cnt <= (motor_run != last) ? 0 : cnt + 1;
    // a jammed spindle never reaches speed
    at_speed <= motor_run && last && !jam && cnt > 40;
    spindle_stopped <= !motor_run && !last && cnt > 40;
    at_track0 <= head_load && at_speed;
  end
endmodule // spsq_mech

/* File: bench/spsq_sva.sv */
// port assertions for the spindle power sequencer
`timescale 1ns/10ps
module spsq_sva (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // straps and codes
  input wire local_sel,
  input wire spin_down_code,
  input wire selected,
  // mechanics
  input wire at_speed,
  input wire at_track0,
  input wire fault,
  input wire motor_run,
  input wire head_load,
  // indicators
  input wire ready_led,
  input wire selected_led,
  input wire unit_ready,
  // bus
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_down;
    unit_ready && spin_down_code && !local_sel;
  endsequence
  a_bus_ack:
    assert property (s_take |=> !avs_waitrequest) else $error("bus not acked");
  a_ack_once:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack too long");
  a_ack_cause:
    assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
      else $error("ack without request");
  a_sel_led:
    assert property ($past(rst_n) |-> selected_led == $past(selected))
      else $error("selected led");
  a_ready_mech:
    assert property (unit_ready |-> motor_run && head_load) else $error("ready w/o motor");
  a_ready_entry:
    assert property ($rose(unit_ready) |-> $past(at_speed) && $past(at_track0))
      else $error("ready too early");
  a_steady_led:
    assert property (unit_ready && $past(unit_ready) && $stable(fault) |-> ready_led == !fault)
      else $error("ready led not steady");
  a_down_stop:
    assert property (s_down |=> !unit_ready && !motor_run) else $error("no spin-down");
  a_head_motor:
    assert property (head_load |-> motor_run) else $error("heads without motor");
endmodule // spsq_sva
bind spsq_top spsq_sva chk (.*);

/* File: bench/test_spsq_top.sv */
// self-checking bench for the spindle power sequencer
`timescale 1ns/10ps
`include "spsq_regs.vh"
module test_spsq_top;
  logic clk = 0, rst_n = 0, local_sel = 0, spin_up_code = 0, spin_down_code = 0;
  logic selected = 0, fault = 0, avs_read = 0, avs_write = 0, jam = 0;
  logic [2:0] lun = 3'h2;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0;
  wire at_speed, at_track0, spindle_stopped, motor_run, head_load, ready_led;
  wire selected_led, unit_ready, avs_waitrequest, irq;
  wire [31:0] avs_readdata;
  logic [63:0] exp_q[$];
  int bad_count = 0, check_count = 0, n;
  // one second is 12 clocks here
  spsq_top #(.TICK_CYCLES(4), .MS_PER_S(3)) dut (.*);
  spsq_mech far (.*);
  initial forever #20 clk = ~clk;
  task automatic chk(logic [31:0] g, logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t value mismatch", $time);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic step(int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task automatic rd(logic [4:0] a, logic [31:0] e, logic [31:0] m);
    exp_q.push_back({m, e});
    bus(0, a, 32'h0);
  endtask
  // counts led changes; a lit or dark led stands still
  task automatic blinks(int cy, logic on);
    int t;
    logic p;
    t = 0;
    p = ready_led;
    repeat (cy) begin
      @(negedge clk);
      t += (ready_led !== p);
      p = ready_led;
    end
    chk(t > 3, on);
    @(posedge clk);
  endtask
  always @(posedge clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0)
        chk(1, 0);
      else
        chk(avs_readdata & exp_q[0][63:32], exp_q[0][31:0]);
      if (exp_q.size() != 0)
        void'(exp_q.pop_front());
    end
  initial begin
    step(10000);
    bad_count++;
    close_out();
  end
  initial begin
    n = $urandom(8);
    step(5);
    rst_n <= 1;
    rd(`SPSQ_OFF_CTRL, 32'h000000FA, 32'hFFFFFFFF);
    rd(`SPSQ_OFF_IRQ_EN, 32'h0, 32'hFFFFFFFF);
    rd(`SPSQ_OFF_IRQ_CLR, 32'h0, 32'hFFFFFFFF);
    rd(5'h14, 32'h0, 32'hFFFFFFFF);
    bus(1, `SPSQ_OFF_CTRL, 32'h00000001);
    bus(1, `SPSQ_OFF_IRQ_EN, 32'h0000000F);
    blinks(40, 1);
    rd(`SPSQ_OFF_STATUS, 32'h00000041, 32'h000000FF);
    step(300);
    chk(motor_run, 0);
    spin_up_code <= 1;
    step(1);
    spin_up_code <= 0;
    step(200);
    chk(motor_run, 0);
    blinks(20, 1);
    for (n = 0; n < 60 && motor_run !== 1'b1; n++) step(1);
    chk(motor_run, 1);
    for (n = 0; n < 720 && unit_ready !== 1'b1; n++) step(1);
    chk(unit_ready, 1);
    chk(head_load, 1);
    blinks(20, 0);
    chk(ready_led, 1);
    chk(irq, 1);
    rd(`SPSQ_OFF_STATUS, 32'h0000000C, 32'h0000000F);
    rd(`SPSQ_OFF_IRQ_STAT, 32'h1, 32'hF);
    bus(1, `SPSQ_OFF_IRQ_CLR, 32'h00000001);
    rd(`SPSQ_OFF_IRQ_STAT, 32'h0, 32'hF);
    chk(irq, 0);
    for (n = 0; n < 8; n++) begin
      fault <= n[0];
      selected <= 1'($urandom);
      step(3);
      chk(ready_led, !n[0]);
      chk(selected_led, selected);
    end
    bus(1, `SPSQ_OFF_IRQ_CLR, 32'h00000008);
    spin_down_code <= 1;
    step(1);
    spin_down_code <= 0;
    blinks(20, 1);
    for (n = 0; n < 200 && spindle_stopped !== 1'b1; n++) step(1);
    blinks(40, 0);
    chk(ready_led, 0);
    rd(`SPSQ_OFF_IRQ_STAT, 32'h4, 32'h4);
    jam <= 1;
    spin_up_code <= 1;
    step(1);
    spin_up_code <= 0;
    blinks(20, 1);
    for (n = 0; n < 300 && motor_run !== 1'b1; n++) step(1);
    chk(motor_run, 1);
    for (n = 0; n < 800 && motor_run !== 1'b0; n++) step(1);
    chk(n > 700 && n < 730, 1);
    chk(ready_led, 0);
    rd(`SPSQ_OFF_IRQ_STAT, 32'h2, 32'h2);
    jam <= 0;
    rst_n <= 0;
    local_sel <= 1;
    lun <= 3'h0;
    step(2);
    rst_n <= 1;
    for (n = 0; n < 400 && unit_ready !== 1'b1; n++) step(1);
    chk(unit_ready, 1);
    close_out();
  end
endmodule // test_spsq_top

/* File: design/spsq_regs.vh */
// constants for the spindle power sequencer: offsets, fields, resets, timing
// Operation
// (RQ1) With the start jumper on local, the sequence delay starts right after power-up.
// (RQ2) With the jumper on remote, the delay starts only when a spin-up code arrives.
// (RQ3) The sequence delay is ten seconds times the logical unit address, 0 to 7.
// (RQ4) The ready indicator blinks from power-up until speed and heads are reached.
// (RQ5) After the delay the motor spins up and heads go to track zero within 60 s.
// (RQ6) The ready indicator is steady on only while powered up and free of faults.
// (RQ7) In remote operation a spin-down code starts the spin-down sequence.
// (RQ8) The ready indicator blinks throughout a commanded spin-down.
// (RQ9) After a remote spin-down completes, the ready indicator stays dark.
// (RQ10) The selected indicator is lit while a controller has the drive selected.
// (RQ11) A readable unit-ready bit is set once the power-on sequence is complete.
// (RQ12) Blink and delay timing come from a prescaled counter on the system clock.
`ifndef SPSQ_REGS_VH
`define SPSQ_REGS_VH

// register byte offsets
`define SPSQ_OFF_CTRL 5'h00
`define SPSQ_OFF_STATUS 5'h04
`define SPSQ_OFF_IRQ_STAT 5'h08
`define SPSQ_OFF_IRQ_CLR 5'h0C
`define SPSQ_OFF_IRQ_EN 5'h10

// control fields
`define SPSQ_CTRL_BLINK_LSB 0
`define SPSQ_CTRL_BLINK_MSB 15
`define SPSQ_CTRL_RST 16'h00FA
`define SPSQ_IRQ_EN_RST 4'h0

// status fields
`define SPSQ_ST_STATE_LSB 0
`define SPSQ_ST_READY_BIT 3
`define SPSQ_ST_LOCAL_BIT 4
`define SPSQ_ST_LUN_LSB 5
`define SPSQ_ST_FAULT_BIT 8
`define SPSQ_ST_SEL_BIT 9
`define SPSQ_ST_SEC_LSB 16

// interrupt bits
`define SPSQ_IRQ_READY 0
`define SPSQ_IRQ_STALL 1
`define SPSQ_IRQ_DOWN 2
`define SPSQ_IRQ_FAULT 3
`define SPSQ_IRQ_W 4

// timing
`define SPSQ_CLK_NS 40
`define SPSQ_MS_NS 1000000
`define SPSQ_MS_PER_S 1000
`define SPSQ_SEQ_UNIT_S 10
`define SPSQ_SPINUP_MAX_S 60

`endif

/* File: design/spsq_tick.v */
// prescaler producing a one-cycle enable pulse every CYCLES clocks
`timescale 1ns/10ps
module spsq_tick #(
  parameter CYCLES = 25000
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // enable pulse
  output reg tick
);
  reg [31:0] count;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (count >= CYCLES - 1) begin
      count <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule // spsq_tick

/* File: design/spsq_top.v */
// spindle power-on/power-off sequencer with indicators and register slave
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`include "spsq_regs.vh"
module spsq_top #(
  parameter TICK_CYCLES = `SPSQ_MS_NS / `SPSQ_CLK_NS,
  parameter MS_PER_S = `SPSQ_MS_PER_S
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // straps
  input wire local_sel,
  input wire [2:0] lun,
  // function codes from the controller
  input wire spin_up_code,
  input wire spin_down_code,
  input wire selected,
  // drive mechanics
  input wire at_speed,
  input wire at_track0,
  input wire spindle_stopped,
  input wire fault,
  output reg motor_run,
  output reg head_load,
  // indicators and interface status
  output reg ready_led,
  output reg selected_led,
  output reg unit_ready,
  // avalon-mm slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // interrupt
  output reg irq
);
  localparam S_PWR = 3'd0;
  localparam S_WAIT = 3'd1;
  localparam S_DELAY = 3'd2;
  localparam S_SPINUP = 3'd3;
  localparam S_READY = 3'd4;
  localparam S_SPINDN = 3'd5;
  localparam S_OFF = 3'd6;
  localparam S_STALL = 3'd7;

  localparam [6:0] SEQ_UNIT = `SPSQ_SEQ_UNIT_S;
  localparam [6:0] SPINUP_MAX = `SPSQ_SPINUP_MAX_S;
  // sized here so the millisecond count compare stays 16 bits wide
  localparam [15:0] MS_LAST = MS_PER_S - 1;

  // one-hot register select positions
  localparam SEL_CTRL = 0;
  localparam SEL_STATUS = 1;
  localparam SEL_IRQ_STAT = 2;
  localparam SEL_IRQ_CLR = 3;
  localparam SEL_IRQ_EN = 4;

  // true in the states where the indicator blinks
  function blink_state;
    input [2:0] st;
    begin
      blink_state = (st == S_WAIT) || (st == S_DELAY) ||
        (st == S_SPINUP) || (st == S_SPINDN);
    end
  endfunction

  // one-hot register select; unmapped offsets select nothing
  function [4:0] reg_sel;
    input [4:0] addr;
    begin
      if (addr == `SPSQ_OFF_CTRL) begin
        reg_sel = 5'h01;
      end else if (addr == `SPSQ_OFF_STATUS) begin
        reg_sel = 5'h02;
      end else if (addr == `SPSQ_OFF_IRQ_STAT) begin
        reg_sel = 5'h04;
      end else if (addr == `SPSQ_OFF_IRQ_CLR) begin
        reg_sel = 5'h08;
      end else if (addr == `SPSQ_OFF_IRQ_EN) begin
        reg_sel = 5'h10;
      end else begin
        reg_sel = 5'h00;
      end
    end
  endfunction

  reg [2:0] state;
  reg [2:0] next_state;
  reg [6:0] sec_cnt;
  reg [15:0] ms_cnt;
  reg sec_tick;
  reg [15:0] blink_cnt;
  reg blink_phase;
  reg [15:0] blink_half;
  reg [`SPSQ_IRQ_W-1:0] irq_stat;
  reg [`SPSQ_IRQ_W-1:0] irq_en;
  wire [`SPSQ_IRQ_W-1:0] next_irq_stat;
  reg [`SPSQ_IRQ_W-1:0] events;
  reg fault_q;
  reg acked;
  wire ms_tick;
  wire [6:0] delay_s;
  wire remote;
  wire req;
  wire take;
  wire [31:0] status_word;
  wire commit;
  wire clr_hit;
  wire [4:0] sel;

  assign remote = ~local_sel;
  // lun 0 gives no delay: seconds >= 0 holds on entry
  assign delay_s = SEQ_UNIT * {4'h0, lun}; // [RQ3]
  assign req = avs_read | avs_write;
  assign take = req & ~acked;

  spsq_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(ms_tick)
  );

  // seconds out of millisecond ticks
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt <= 16'h0000;
      sec_tick <= 1'b0;
    end else if (ms_tick) begin
      if (ms_cnt >= MS_LAST) begin
        ms_cnt <= 16'h0000;
        sec_tick <= 1'b1; // [RQ12]
      end else begin
        ms_cnt <= ms_cnt + 16'h0001;
        sec_tick <= 1'b0;
      end
    end else begin
      sec_tick <= 1'b0;
    end
  end

  // blink phase, half period in ms from the control register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt <= 16'h0000;
      blink_phase <= 1'b0;
    end else if (ms_tick) begin
      if (blink_cnt + 16'h0001 >= blink_half) begin
        blink_cnt <= 16'h0000;
        blink_phase <= ~blink_phase; // [RQ12]
      end else begin
        blink_cnt <= blink_cnt + 16'h0001;
      end
    end
  end

  // sequence state machine
  always @* begin
    next_state = state;
    case (state)
      S_PWR: begin
        // jumper read one cycle after reset release, not under reset
        if (local_sel) begin
          next_state = S_DELAY; // [RQ1]
        end else if (spin_up_code) begin
          next_state = S_DELAY; // [RQ2]
        end else begin
          next_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (spin_up_code) begin
          next_state = S_DELAY; // [RQ2]
        end
      end
      S_DELAY: begin
        if (remote && spin_down_code) begin
          next_state = S_SPINDN; // [RQ7]
        end else if (sec_cnt >= delay_s) begin
          next_state = S_SPINUP; // [RQ3]
        end
      end
      S_SPINUP: begin
        if (remote && spin_down_code) begin
          next_state = S_SPINDN; // [RQ7]
        end else if (at_speed && at_track0) begin
          next_state = S_READY; // [RQ5]
        end else if (sec_cnt >= SPINUP_MAX) begin
          next_state = S_STALL; // [RQ5]
        end
      end
      S_READY: begin
        if (remote && spin_down_code) begin
          next_state = S_SPINDN; // [RQ7]
        end
      end
      S_SPINDN: begin
        // no timeout here: the motor only coasts, nothing to retry
        if (spindle_stopped) begin
          next_state = S_OFF;
        end
      end
      S_OFF: begin
        if (remote && spin_up_code) begin
          next_state = S_DELAY; // [RQ2]
        end
      end
      S_STALL: begin
        // only a fresh remote spin-up retries; local needs a power cycle
        if (remote && spin_up_code) begin
          next_state = S_DELAY;
        end
      end
      default: begin
        next_state = S_PWR;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_PWR;
      sec_cnt <= 7'h00;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        sec_cnt <= 7'h00;
      // saturate rather than wrap, so a stuck state never looks fresh
      end else if (sec_tick && sec_cnt != 7'h7F) begin
        sec_cnt <= sec_cnt + 7'h01;
      end
    end
  end

  // mechanics and indicators, all registered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_run <= 1'b0;
      head_load <= 1'b0;
      ready_led <= 1'b0;
      selected_led <= 1'b0;
      unit_ready <= 1'b0;
    end else begin
      motor_run <= (next_state == S_SPINUP) || (next_state == S_READY); // [RQ5]
      head_load <= ((next_state == S_SPINUP) && at_speed) ||
        (next_state == S_READY); // [RQ5]
      if (blink_state(next_state)) begin
        ready_led <= blink_phase; // [RQ4] [RQ8]
      end else if (next_state == S_READY) begin
        ready_led <= ~fault; // [RQ6]
      end else begin
        ready_led <= 1'b0; // [RQ9]
      end
      selected_led <= selected; // [RQ10]
      unit_ready <= (next_state == S_READY); // [RQ11]
    end
  end

  // interrupt events
  always @* begin
    events = {`SPSQ_IRQ_W{1'b0}};
    events[`SPSQ_IRQ_READY] = (next_state == S_READY) && (state != S_READY);
    events[`SPSQ_IRQ_STALL] = (next_state == S_STALL) && (state != S_STALL);
    events[`SPSQ_IRQ_DOWN] = (next_state == S_OFF) && (state != S_OFF);
    events[`SPSQ_IRQ_FAULT] = fault && ~fault_q;
  end

  // one decode shared by the write and read paths
  assign sel = reg_sel(avs_address);
  // writes land on the ack edge, the one the master completes on
  assign commit = acked & avs_write;
  assign clr_hit = commit & sel[SEL_IRQ_CLR];

  // a set in the same cycle as a clear wins, per bit
  genvar gi;
  generate
    for (gi = 0; gi < `SPSQ_IRQ_W; gi = gi + 1) begin : g_irq
      assign next_irq_stat[gi] = events[gi] |
        (irq_stat[gi] & ~(clr_hit & avs_writedata[gi]));
    end
  endgenerate

  assign status_word = {9'h000, sec_cnt, 6'h00, selected_led, fault,
    lun, local_sel, unit_ready, state};

  // bus handshake: one wait cycle, then a single ack cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acked <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      acked <= take;
      avs_waitrequest <= ~take;
    end
  end

  // writable registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_half <= `SPSQ_CTRL_RST;
      irq_en <= `SPSQ_IRQ_EN_RST;
    end else if (commit) begin
      if (sel[SEL_CTRL]) begin
        blink_half <= avs_writedata[`SPSQ_CTRL_BLINK_MSB:`SPSQ_CTRL_BLINK_LSB];
      end else if (sel[SEL_IRQ_EN]) begin
        irq_en <= avs_writedata[`SPSQ_IRQ_W-1:0];
      end
    end
  end

  // sticky interrupt status and the level output
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= {`SPSQ_IRQ_W{1'b0}};
      fault_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      fault_q <= fault;
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_en);
    end
  end

  // read data captured on the taking edge, stands through the ack cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (take && avs_read) begin
      if (sel[SEL_CTRL]) begin
        avs_readdata <= {16'h0000, blink_half};
      end else if (sel[SEL_STATUS]) begin
        avs_readdata <= status_word;
      end else if (sel[SEL_IRQ_STAT]) begin
        avs_readdata <= {28'h0000000, irq_stat};
      end else if (sel[SEL_IRQ_EN]) begin
        avs_readdata <= {28'h0000000, irq_en};
      end else begin
        // unmapped and write-only offsets read as zero
        avs_readdata <= 32'h0000_0000;
      end
    end
  end
endmodule // spsq_top
